//--- hw/hvm_route_ctrl.sv
`timescale 1ns/10ps
module hvm_route_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register writes and mode
    input wire hvm_pkg::hvm_write_type wr,
    input wire hvm_pkg::hvm_mode_type mode,
    input wire logic sleep_cmd,
    input wire logic timer_wake_en,
    input wire logic can_wake_en,
    // Raw pin levels
    input wire logic sense_pin,
    input wire logic gen_pin,
    // Status and control out
    output hvm_pkg::hvm_pin_ctl_type pin_ctl,
    output logic measure_enable_bit,
    output logic [hvm_pkg::PIN_CFG_W-1:0] pin_cfg,
    output logic [hvm_pkg::PULL_W-1:0] wake_pull_config,
    output logic wake_control_second,
    output logic wake_input_enable,
    output logic cmd_fault,
    output logic sleep_to_restart,
    output logic sleep_go,
    output logic sense_level,
    output logic gen_level,
    output hvm_pkg::hvm_state_type state
);

    logic meas_q;
    logic meas_d;
    logic [hvm_pkg::PIN_CFG_W-1:0] cfg_q;
    logic [hvm_pkg::PIN_CFG_W-1:0] cfg_d;
    logic [hvm_pkg::PULL_W-1:0] pull_q;
    logic ctl2_q;
    logic wken_q;
    logic fault_q;
    logic fault_d;
    logic restart_q;
    logic sleep_q;
    logic sense_lvl_q;
    logic gen_lvl_q;
    logic [1:0] pins_sync;
    hvm_pkg::hvm_state_type state_q;
    hvm_pkg::hvm_state_type state_d;
    hvm_pkg::hvm_pin_ctl_type ctl_q;
    hvm_pkg::hvm_pin_ctl_type ctl_d;

    // Pins come from outside the clock domain
    hvm_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({sense_pin, gen_pin}),
        .dout(pins_sync)
    );

    wire in_normal = (mode == hvm_pkg::HVM_NORMAL);
    wire cfg_is_off = (cfg_q == hvm_pkg::PIN_CFG_OFF);
    wire gen_is_wake = (cfg_q == hvm_pkg::PIN_CFG_WAKE);
    wire meas_set_try = wr.meas_wr && wr.meas_val && !meas_q;
    wire meas_refused = meas_set_try && !cfg_is_off; // [R9]
    wire cfg_change_bad = meas_q && wr.pin_cfg_wr && (wr.pin_cfg_val != cfg_q); // [R8]
    // Any other wake source keeps Sleep legal
    wire other_wake = timer_wake_en || can_wake_en;
    wire pin_wake_only = (wken_q || gen_is_wake) && !other_wake;
    wire sleep_bad = meas_q && sleep_cmd && pin_wake_only; // [R6]
    wire pins_live = !meas_q; // [R3] [R5] [R7]

    always_comb
    begin
        meas_d = meas_q;
        if (wr.meas_wr && !meas_refused)
            meas_d = wr.meas_val;
        cfg_d = cfg_q;
        // Rejected changes are dropped too, so the pin keeps its configuration under measurement
        if (wr.pin_cfg_wr && !cfg_change_bad)
            cfg_d = wr.pin_cfg_val;
        fault_d = fault_q || meas_refused || cfg_change_bad || sleep_bad;
    end

    always_comb
    begin
        case (state_q)
            hvm_pkg::HVM_OFF: state_d = meas_q ? hvm_pkg::HVM_ARMED : hvm_pkg::HVM_OFF;
            hvm_pkg::HVM_ARMED,
            hvm_pkg::HVM_ROUTED:
            begin
                if (!meas_q)
                    state_d = hvm_pkg::HVM_OFF;
                else if (in_normal)
                    state_d = hvm_pkg::HVM_ROUTED; // [R2] [R12]
                else
                    state_d = hvm_pkg::HVM_ARMED; // [R10]
            end
            default: state_d = hvm_pkg::HVM_OFF;
        endcase
    end

    always_comb
    begin
        ctl_d.switch_close = meas_q && in_normal; // [R2] [R10] [R12]
        ctl_d.pull_enable = pins_live; // [R3] [R4]
        ctl_d.pull_sel = pins_live ? pull_q : hvm_pkg::PULL_RST; // [R4]
        ctl_d.sense_to_logic = pins_live; // [R3]
        ctl_d.pin_to_logic = pins_live; // [R3]
        ctl_d.fail_out_en = pins_live && (cfg_q == hvm_pkg::PIN_CFG_FAIL); // [R7]
        ctl_d.gpio_en = pins_live && !cfg_is_off; // [R4] [R7]
        ctl_d.wake_detect_en = pins_live && (wken_q || ctl2_q); // [R7] [R11]
        ctl_d.status_update_en = pins_live; // [R5]
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meas_q <= 1'b0; // [R1]
            cfg_q <= hvm_pkg::PIN_CFG_RST;
            pull_q <= hvm_pkg::PULL_RST;
            ctl2_q <= 1'b0;
            wken_q <= 1'b0;
            fault_q <= 1'b0;
            state_q <= hvm_pkg::HVM_OFF;
        end
        else
        begin
            meas_q <= meas_d;
            cfg_q <= cfg_d;
            if (wr.pull_wr)
                pull_q <= wr.pull_val; // [R4]
            if (wr.wake_ctl2_wr)
                ctl2_q <= wr.wake_ctl2_val; // [R4]
            if (wr.sense_wake_wr)
                wken_q <= wr.sense_wake_val; // [R11]
            fault_q <= fault_d;
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctl_q <= '0;
            restart_q <= 1'b0;
            sleep_q <= 1'b0;
            sense_lvl_q <= 1'b0;
            gen_lvl_q <= 1'b0;
        end
        else
        begin
            ctl_q <= ctl_d;
            restart_q <= sleep_bad; // [R6]
            sleep_q <= sleep_cmd && !sleep_bad;
            // Levels freeze while the pins are gated
            if (pins_live)
            begin
                sense_lvl_q <= pins_sync[1]; // [R5]
                gen_lvl_q <= pins_sync[0]; // [R5]
            end
        end
    end

    assign pin_ctl = ctl_q;
    assign measure_enable_bit = meas_q;
    assign pin_cfg = cfg_q;
    assign wake_pull_config = pull_q;
    assign wake_control_second = ctl2_q;
    assign wake_input_enable = wken_q;
    assign cmd_fault = fault_q;
    assign sleep_to_restart = restart_q;
    assign sleep_go = sleep_q;
    assign sense_level = sense_lvl_q;
    assign gen_level = gen_lvl_q;
    assign state = state_q;

endmodule

//--- hw/hvm_pkg.sv
// Operation
// R1: After reset measurement is off, switch open, pins keep normal function.
// R2: Enable set closes switch only in Normal mode; configuration kept otherwise.
// R3: While enabled, pin pull currents off and pin inputs gated from logic.
// R4: While enabled, pull, second wake control and pin config ignored but writable. The code drops pin config writes that change it.
// R5: While enabled, wake status and level status not updated from the pins.
// R6: Sleep command with only sense or pin wake enabled: fault flag, Restart.
// R7: While enabled, no fail output, fail test, general pin, or pin wake.
// R8: Changing general pin configuration while enabled sets the fault flag.
// R9: Enable refused with fault flag unless general pin configured Off first.
// R10: Fail-Safe entry keeps enable setting but opens the switch.
// R11: Sense wake enable stays writable but has no effect while enabled.
// R12: Switch control follows enable and mode, recloses on Normal re-entry.
package hvm_pkg;

    localparam int unsigned PIN_CFG_W = 3;
    localparam int unsigned PULL_W = 2;
    localparam logic [PIN_CFG_W-1:0] PIN_CFG_OFF = 3'h0;
    localparam logic [PIN_CFG_W-1:0] PIN_CFG_FAIL = 3'h1;
    localparam logic [PIN_CFG_W-1:0] PIN_CFG_WAKE = 3'h2;
    localparam logic [PIN_CFG_W-1:0] PIN_CFG_RST = PIN_CFG_FAIL;
    localparam logic [PULL_W-1:0] PULL_RST = 2'h0;

    typedef enum logic [2:0]
    {
        HVM_NORMAL = 3'h1,
        HVM_SLEEP = 3'h2,
        HVM_OTHER = 3'h4
    } hvm_mode_type;

    typedef enum logic [2:0]
    {
        HVM_OFF = 3'h1,
        HVM_ARMED = 3'h2,
        HVM_ROUTED = 3'h4
    } hvm_state_type;

    // One register write from the host side
    typedef struct packed {
        logic meas_wr;
        logic meas_val;
        logic pin_cfg_wr;
        logic [PIN_CFG_W-1:0] pin_cfg_val;
        logic pull_wr;
        logic [PULL_W-1:0] pull_val;
        logic wake_ctl2_wr;
        logic wake_ctl2_val;
        logic sense_wake_wr;
        logic sense_wake_val;
    } hvm_write_type;

    // Pin-side effects seen by the rest of the chip
    typedef struct packed {
        logic switch_close;
        logic pull_enable;
        logic [PULL_W-1:0] pull_sel;
        logic sense_to_logic;
        logic pin_to_logic;
        logic fail_out_en;
        logic gpio_en;
        logic wake_detect_en;
        logic status_update_en;
    } hvm_pin_ctl_type;

endpackage

//--- hw/hvm_sync.sv
`timescale 1ns/10ps
module hvm_sync #(
    parameter int unsigned WIDTH = 2
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial
    begin
        if (WIDTH < 1)
            $error("hvm_sync width must be at least one");
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

//--- dv/hvm_route_checker.sv
`timescale 1ns/10ps
module hvm_route_checker (
    // Clock, reset and requests
    input wire logic clk,
    input wire logic sys_rst,
    input wire hvm_pkg::hvm_write_type wr,
    input wire hvm_pkg::hvm_mode_type mode,
    input wire logic sleep_cmd,
    input wire logic timer_wake_en,
    input wire logic can_wake_en,
    // Results
    input wire hvm_pkg::hvm_pin_ctl_type pin_ctl,
    input wire logic measure_enable_bit,
    input wire logic [hvm_pkg::PIN_CFG_W-1:0] pin_cfg,
    input wire logic [hvm_pkg::PULL_W-1:0] wake_pull_config,
    input wire logic wake_input_enable,
    input wire logic cmd_fault,
    input wire logic sleep_to_restart
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sw_follow_a: assert property (pin_ctl.switch_close ==
        $past(measure_enable_bit && mode == hvm_pkg::HVM_NORMAL)) else $error("switch");
    pull_gate_a: assert property (measure_enable_bit |=>
        !(pin_ctl.pull_enable || pin_ctl.sense_to_logic || pin_ctl.pin_to_logic))
        else $error("pull gate");
    pin_func_a: assert property (measure_enable_bit |=>
        !(pin_ctl.fail_out_en || pin_ctl.gpio_en || pin_ctl.wake_detect_en)) else $error("func");
    status_gate_a: assert property (measure_enable_bit |=>
        !pin_ctl.status_update_en) else $error("status");
    cfg_lock_a: assert property (measure_enable_bit && wr.pin_cfg_wr &&
        wr.pin_cfg_val != pin_cfg |=> cmd_fault && $stable(pin_cfg)) else $error("cfg");
    arm_refuse_a: assert property (wr.meas_wr && wr.meas_val && !measure_enable_bit &&
        pin_cfg != hvm_pkg::PIN_CFG_OFF |=> cmd_fault && !measure_enable_bit) else $error("arm");
    sleep_refuse_a: assert property (sleep_cmd && measure_enable_bit &&
        wake_input_enable && !timer_wake_en && !can_wake_en |=> sleep_to_restart && cmd_fault)
        else $error("sleep");
    pull_write_a: assert property (wr.pull_wr |=>
        wake_pull_config == $past(wr.pull_val)) else $error("pull write");
    cover property (sleep_to_restart);
    cover property (pin_ctl.switch_close);
    cover property (measure_enable_bit && wr.pin_cfg_wr);
endmodule

bind hvm_route_ctrl hvm_route_checker u_chk (.clk, .sys_rst, .wr, .mode, .sleep_cmd,
    .timer_wake_en, .can_wake_en, .pin_ctl, .measure_enable_bit, .pin_cfg,
    .wake_pull_config, .wake_input_enable, .cmd_fault, .sleep_to_restart);

//--- dv/hvm_host.sv
`timescale 1ns/10ps
module hvm_host (
    // Host side of the register link
    input wire logic clk,
    output hvm_pkg::hvm_write_type wr = '0,
    output logic sleep_cmd = 1'b0
);
    // One-cycle strobes, raised and dropped on falling edges
    task automatic put(input hvm_pkg::hvm_write_type v);
        @(negedge clk);
        wr = v;
        @(negedge clk);
        wr = '0;
    endtask
    task automatic sleep();
        @(negedge clk);
        sleep_cmd = 1'b1;
        @(negedge clk);
        sleep_cmd = 1'b0;
    endtask
endmodule

//--- dv/hv_measure_route_control_test.sv
`timescale 1ns/10ps
module hv_measure_route_control_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic timer_wake_en = 1'b0;
    logic [1:0] pins = 2'h0;
    hvm_pkg::hvm_mode_type mode = hvm_pkg::HVM_NORMAL;
    hvm_pkg::hvm_write_type wr, w;
    hvm_pkg::hvm_pin_ctl_type pc;
    logic sleep_cmd, meas, wie, fault, to_rst, go;
    logic [2:0] cfg;
    logic [1:0] pull;
    logic sl, gl, ctl2;
    logic [1:0] h1, h2, h3, fz;
    hvm_pkg::hvm_state_type st;
    int fails = 0, compares = 0, cyc = 0, m_meas, m_cfg, m_fault;
    always #2 clk = ~clk;
    always @(negedge clk) pins = 2'($urandom);
    // Pin history: levels appear two edges after the pin is sampled
    always @(posedge clk)
    begin
        h1 <= pins;
        h2 <= h1;
        h3 <= h2;
    end
    hvm_host host (.clk, .wr, .sleep_cmd);
    hvm_route_ctrl DUT (.clk, .sys_rst, .wr, .mode, .sleep_cmd, .timer_wake_en,
        .can_wake_en(1'b0), .sense_pin(pins[0]), .gen_pin(pins[1]), .pin_ctl(pc),
        .measure_enable_bit(meas), .pin_cfg(cfg), .wake_pull_config(pull),
        .wake_control_second(ctl2), .wake_input_enable(wie), .cmd_fault(fault),
        .sleep_to_restart(to_rst), .sleep_go(go), .sense_level(sl), .gen_level(gl), .state(st));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic put(input hvm_pkg::hvm_write_type v);
        host.put(v);
        if (v.pin_cfg_wr && m_meas == 1 && v.pin_cfg_val != m_cfg)
            m_fault = 1;
        else if (v.pin_cfg_wr && m_meas == 0)
            m_cfg = v.pin_cfg_val;
        if (v.meas_wr && v.meas_val && m_cfg != 0)
            m_fault = 1;
        else if (v.meas_wr)
            m_meas = v.meas_val;
        chk({meas, cfg, fault}, {m_meas[0], m_cfg[2:0], m_fault[0]});
    endtask
    task automatic slp(input logic rs);
        host.sleep();
        m_fault = m_fault | rs;
        chk({to_rst, go, fault}, {rs, !rs, m_fault[0]});
    endtask
    task automatic rst();
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        chk({meas, cfg, fault}, 5'h02);
        sys_rst = 1'b0;
        m_meas = 0;
        m_cfg = 1;
        m_fault = 0;
    endtask
    task automatic report_and_stop(input int extra);
        fails += extra;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
        if (++cyc == 2000)
            report_and_stop(1);
    // Codes: 1800 arm, 0400 pin Off, 0500 pin wake, 004f pull, second wake control and sense wake
    initial
    begin
        void'($urandom(79));
        rst();
        @(negedge clk);
        chk({pc.switch_close, pc.pull_enable, pc.status_update_en}, 5'h03);
        slp(1'b0);
        chk({sl, gl}, {h3[0], h3[1]});
        put(13'h1800);
        $display("test refuse done");
        rst();
        put(13'h0400);
        put(13'h1800);
        @(negedge clk);
        chk({pc.pull_enable, pc.sense_to_logic, pc.pin_to_logic, pc.gpio_en,
            pc.fail_out_en}, 5'h00);
        fz = {sl, gl};
        for (int i = 0; i < 3; i++)
        begin
            mode = hvm_pkg::hvm_mode_type'(3'h1 << ((i + 1) % 3));
            @(negedge clk);
            chk({pc.switch_close, meas, st, sl, gl},
                {i == 2, 1'b1, (i == 2) ? 3'h4 : 3'h2, fz});
        end
        w = 13'h004f | 13'(($urandom % 4) << 4);
        put(w);
        chk({pull, wie, ctl2}, {w.pull_val, 2'b11});
        put(13'h0400);
        put(13'h0500);
        slp(1'b1);
        timer_wake_en = 1'b1;
        slp(1'b0);
        $display("test route done");
        report_and_stop(0);
    end
endmodule
